//--- logic/rmc_pkg.sv
// Constants and carriers for the main configuration register pair.
// Assumes a byte-wide host register port decoded outside this block.
package rmc_pkg;
    localparam logic [4:0] RMC_ADDR_POWER_RF  = 5'h00;
    localparam logic [4:0] RMC_ADDR_PROTOCOL  = 5'h01;
    localparam logic [4:0] RMC_ADDR_FIFO      = 5'h1f;
    localparam logic [7:0] RMC_POWER_RF_RST   = 8'h01;
    localparam logic [7:0] RMC_PROTOCOL_RST   = 8'h02;
    localparam int         RMC_STANDBY_BIT    = 7;
    localparam int         RMC_RAW_BIT        = 6;
    localparam int         RMC_CARRIER_BIT    = 5;
    localparam int         RMC_HALF_PWR_BIT   = 4;
    localparam int         RMC_PRIMARY_BIT    = 3;
    localparam int         RMC_AGC_BIT        = 2;
    localparam int         RMC_RX_FORCE_BIT   = 1;
    localparam int         RMC_SUPPLY_BIT     = 0;
    localparam int         RMC_NO_CRC_BIT     = 7;
    localparam int         RMC_VARIANT_BIT    = 6;
    localparam int         RMC_TAG_MODE_BIT   = 5;
    localparam int         RMC_CODE_MSB       = 4;
    localparam logic [4:0] RMC_CODE_DEFAULT   = 5'h02;
    localparam int         RMC_WAKE_TIME_US   = 100;
    localparam int         RMC_CLK_MHZ        = 100;
    localparam int         RMC_WAKE_CYCLES    = RMC_WAKE_TIME_US * RMC_CLK_MHZ;
    localparam int         RMC_WAKE_W         = 14;

    typedef enum logic [1:0] {
        RMC_FAM_VICINITY = 2'b00,
        RMC_FAM_PROX_A   = 2'b01,
        RMC_FAM_PROX_B   = 2'b10,
        RMC_FAM_OTHER    = 2'b11
    } rmc_family_t;

    typedef enum logic [1:0] {
        RMC_PW_ACTIVE  = 2'b00,
        RMC_PW_STANDBY = 2'b01,
        RMC_PW_WAKING  = 2'b10
    } rmc_pstate_t;

    typedef struct packed {
        logic        standby;
        logic        ready;
        logic        raw_mode;
        logic        raw_variant;
        logic        tx_on;
        logic        rx_on;
        logic        half_power;
        logic        main_input;
        logic        agc_on;
        logic        supply_5v;
        logic        no_rx_crc;
        logic [4:0]  protocol_code;
        rmc_family_t family;
    } rmc_ctrl_t;
endpackage

//--- logic/rmc_reg_store.sv
// Two-entry configuration store with registered read data.
// Assumes the caller gives one write strobe per byte write.
`timescale 1ns/1ns
module rmc_reg_store
    import rmc_pkg::*;
(
    input  wire logic       i_clk,     // System clock
    input  wire logic       i_reset,   // Async reset, active high
    input  wire logic       i_ce,      // Clock enable
    input  wire logic       i_clr,     // Sync preset
    input  wire logic       i_wr,      // Write strobe
    input  wire logic       i_sel,     // Entry select
    input  wire logic [7:0] i_wdata,   // Write data
    output logic      [7:0] o_rdata,   // Registered read data
    output logic      [7:0] o_pwr,     // Entry 0 value
    output logic      [7:0] o_proto    // Entry 1 value
);
    logic [7:0] mem_r [2];
    logic [7:0] mem_nxt [2];
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    localparam logic [7:0] RST_VAL [2] = '{RMC_POWER_RF_RST,
                                          RMC_PROTOCOL_RST};

    for (genvar g = 0; g < 2; g++) begin : g_ent
        always_comb begin
            mem_nxt[g] = mem_r[g];
            if (i_clr) begin
                mem_nxt[g] = RST_VAL[g];
            end else if (i_wr && (i_sel == 1'(g))) begin
                mem_nxt[g] = i_wdata;
            end
        end
        always_ff @(posedge i_clk or posedge i_reset) begin
            if (i_reset) begin
                mem_r[g] <= RST_VAL[g];
            end else if (i_ce) begin
                mem_r[g] <= mem_nxt[g];
            end
        end
    end

    always_comb begin
        rdata_nxt = mem_r[i_sel];
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rdata_r <= 8'h00;
        end else if (i_ce) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign o_rdata = rdata_r;
    assign o_pwr   = mem_r[0];
    assign o_proto = mem_r[1];
endmodule

//--- logic/rmc_main_config.sv
// Main configuration register pair and decoded front-end controls.
// Assumes a synchronous byte port from the host interface logic.
`timescale 1ns/1ns
module rmc_main_config
    import rmc_pkg::*;
(
    input  wire logic       i_clk,        // 100 MHz system clock
    input  wire logic       i_reset,      // Power-on reset, async high
    input  wire logic       i_ce,         // Clock enable
    input  wire logic       i_chip_en,    // Chip enable, low presets
    input  wire logic       i_wr,         // Register write strobe
    input  wire logic       i_rd,         // Register read strobe
    input  wire logic [4:0] i_addr,       // Register address
    input  wire logic [7:0] i_wdata,      // Write data
    output logic      [7:0] o_rdata,      // Read data
    output logic            o_rd_valid,   // Read data valid pulse
    output logic            o_fifo_wr,    // FIFO port write pulse
    output logic            o_fifo_rd,    // FIFO port read pulse
    output logic            o_opt_reload, // Option default reload pulse
    output rmc_ctrl_t       o_ctrl        // Decoded controls
);
    logic       clr;
    logic       hit_pwr;
    logic       hit_proto;
    logic       hit;
    logic [7:0] pwr;
    logic [7:0] proto;

    assign clr       = !i_chip_en;
    assign hit_pwr   = (i_addr == RMC_ADDR_POWER_RF);
    assign hit_proto = (i_addr == RMC_ADDR_PROTOCOL);
    assign hit       = hit_pwr || hit_proto;

    rmc_reg_store u_store (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_ce    (i_ce),
        .i_clr   (clr),
        .i_wr    (i_wr && hit),
        .i_sel   (hit_proto),
        .i_wdata (i_wdata),
        .o_rdata (),
        .o_pwr   (pwr),
        .o_proto (proto)
    );

    // Strobe stage
    logic rd_valid_r, rd_valid_nxt;
    logic rd_hit_r, rd_hit_nxt;
    logic fifo_wr_r, fifo_wr_nxt;
    logic fifo_rd_r, fifo_rd_nxt;
    logic reload_r, reload_nxt;
    logic [7:0] rdata_r, rdata_nxt;

    always_comb begin
        rd_valid_nxt = i_rd && !clr;
        rd_hit_nxt   = i_rd && hit;
        // Mux ahead of the flop so the port comes straight from a register
        rdata_nxt    = 8'h00;
        if (rd_hit_nxt) begin
            rdata_nxt = hit_proto ? proto : pwr;
        end
        fifo_wr_nxt  = i_wr && !clr && (i_addr == RMC_ADDR_FIFO);
        fifo_rd_nxt  = i_rd && !clr && (i_addr == RMC_ADDR_FIFO);
        // Reload on every protocol register write, even of the same code
        reload_nxt   = clr || (i_wr && hit_proto);
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rd_valid_r <= 1'b0;
            rd_hit_r   <= 1'b0;
            fifo_wr_r  <= 1'b0;
            fifo_rd_r  <= 1'b0;
            reload_r   <= 1'b1;
            rdata_r    <= 8'h00;
        end else if (i_ce) begin
            rdata_r    <= rdata_nxt;
            rd_valid_r <= rd_valid_nxt;
            rd_hit_r   <= rd_hit_nxt;
            fifo_wr_r  <= fifo_wr_nxt;
            fifo_rd_r  <= fifo_rd_nxt;
            reload_r   <= reload_nxt;
        end
    end

    // Unmapped reads return zero; only a FIFO-address read has a side effect, the o_fifo_rd pulse
    assign o_rdata      = rdata_r;
    assign o_rd_valid   = rd_valid_r;
    assign o_fifo_wr    = fifo_wr_r;
    assign o_fifo_rd    = fifo_rd_r;
    assign o_opt_reload = reload_r;

    // Standby and wake-up timing
    rmc_pstate_t           pst_r, pst_nxt;
    logic [RMC_WAKE_W-1:0] wake_cnt_r, wake_cnt_nxt;

    always_comb begin
        pst_nxt      = pst_r;
        wake_cnt_nxt = wake_cnt_r;
        unique case (pst_r)
            RMC_PW_ACTIVE: begin
                if (pwr[RMC_STANDBY_BIT]) begin
                    pst_nxt = RMC_PW_STANDBY;
                end
            end
            RMC_PW_STANDBY: begin
                if (!pwr[RMC_STANDBY_BIT]) begin
                    pst_nxt      = RMC_PW_WAKING;
                    wake_cnt_nxt = RMC_WAKE_W'(RMC_WAKE_CYCLES - 1);
                end
            end
            RMC_PW_WAKING: begin
                if (pwr[RMC_STANDBY_BIT]) begin
                    pst_nxt = RMC_PW_STANDBY;
                end else if (wake_cnt_r == '0) begin
                    pst_nxt = RMC_PW_ACTIVE;
                end else begin
                    wake_cnt_nxt = wake_cnt_r - 1'b1;
                end
            end
            default: pst_nxt = RMC_PW_ACTIVE;
        endcase
        if (clr) begin
            pst_nxt      = RMC_PW_ACTIVE;
            wake_cnt_nxt = '0;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pst_r      <= RMC_PW_ACTIVE;
            wake_cnt_r <= '0;
        end else if (i_ce) begin
            pst_r      <= pst_nxt;
            wake_cnt_r <= wake_cnt_nxt;
        end
    end

    // Decoded control outputs
    rmc_ctrl_t ctrl_r, ctrl_nxt;

    function automatic rmc_family_t fam_of(input logic [4:0] code);
        rmc_family_t f;
        f = RMC_FAM_OTHER;
        if (code[4:3] == 2'b00) begin
            f = RMC_FAM_VICINITY;
        end else if (code[4:2] == 3'b010) begin
            f = RMC_FAM_PROX_A;
        end else if (code[4:2] == 3'b011) begin
            f = RMC_FAM_PROX_B;
        end
        return f;
    endfunction

    always_comb begin
        ctrl_nxt               = ctrl_r;
        ctrl_nxt.standby       = pwr[RMC_STANDBY_BIT];
        ctrl_nxt.ready         = (pst_nxt == RMC_PW_ACTIVE);
        ctrl_nxt.raw_mode      = pwr[RMC_RAW_BIT];
        // Variant latched only on raw entry; host sets it first
        if (pwr[RMC_RAW_BIT] && !ctrl_r.raw_mode) begin
            ctrl_nxt.raw_variant = proto[RMC_VARIANT_BIT];
        end
        ctrl_nxt.tx_on         = pwr[RMC_CARRIER_BIT];
        ctrl_nxt.rx_on         = pwr[RMC_CARRIER_BIT]
                               || pwr[RMC_RX_FORCE_BIT];
        ctrl_nxt.half_power    = pwr[RMC_HALF_PWR_BIT];
        ctrl_nxt.main_input    = pwr[RMC_PRIMARY_BIT];
        ctrl_nxt.agc_on        = pwr[RMC_AGC_BIT];
        ctrl_nxt.supply_5v     = pwr[RMC_SUPPLY_BIT];
        ctrl_nxt.no_rx_crc     = proto[RMC_NO_CRC_BIT];
        ctrl_nxt.protocol_code = proto[RMC_CODE_MSB:0];
        ctrl_nxt.family        = fam_of(proto[RMC_CODE_MSB:0]);
        if (clr) begin
            ctrl_nxt.raw_variant = 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ctrl_r               <= '0;
            ctrl_r.ready         <= 1'b1;
            ctrl_r.supply_5v     <= RMC_POWER_RF_RST[RMC_SUPPLY_BIT];
            ctrl_r.protocol_code <= RMC_CODE_DEFAULT;
            ctrl_r.family        <= RMC_FAM_VICINITY;
        end else if (i_ce) begin
            ctrl_r <= ctrl_nxt;
        end
    end

    assign o_ctrl = ctrl_r;
endmodule

//--- test/rmc_main_config_sva.sv
// Port checker for the main configuration register pair.
// Assumes it is bound onto every rmc_main_config instance.
`timescale 1ns/1ns
module rmc_main_config_sva
    import rmc_pkg::*;
(
    input wire logic       i_clk,        // clock
    input wire logic       i_reset,      // reset
    input wire logic       i_ce,         // enable
    input wire logic       i_chip_en,    // chip enable
    input wire logic       i_wr,         // write
    input wire logic       i_rd,         // read
    input wire logic [4:0] i_addr,       // address
    input wire logic [7:0] i_wdata,      // write data
    input wire logic [7:0] o_rdata,      // read data
    input wire logic       o_rd_valid,   // read valid
    input wire logic       o_fifo_wr,    // fifo write
    input wire logic       o_fifo_rd,    // fifo read
    input wire logic       o_opt_reload, // reload
    input wire rmc_ctrl_t  o_ctrl        // controls
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    AST_RD_VALID: assert property (i_ce && i_rd && i_chip_en |=> o_rd_valid)
        else $error("read gave no valid pulse");
    AST_RD_UNMAP: assert property (i_ce && i_rd && i_chip_en &&
        i_addr inside {[5'h02:5'h1e]} |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_RELOAD: assert property (i_ce && i_wr && i_addr == 5'h01 |=> o_opt_reload)
        else $error("no option reload after write");
    AST_PRESET: assert property (i_ce && !i_chip_en ##1 i_ce |=>
        o_ctrl.protocol_code == 5'h02 && o_ctrl.supply_5v && !o_ctrl.tx_on)
        else $error("preset not applied");
    AST_PROTO: assert property (i_ce && i_chip_en && i_wr && i_addr == 5'h01
        ##1 i_ce |=> o_ctrl.protocol_code == $past(i_wdata[4:0], 2)
        && o_ctrl.no_rx_crc == $past(i_wdata[7], 2))
        else $error("protocol controls wrong");
    AST_TX_RX: assert property (i_ce && i_chip_en && i_wr && i_addr == 5'h00
        ##1 i_ce |=> o_ctrl.tx_on == $past(i_wdata[5], 2)
        && o_ctrl.rx_on == ($past(i_wdata[5], 2) | $past(i_wdata[1], 2)))
        else $error("carrier or receiver wrong");
    AST_PWR: assert property (i_ce && i_chip_en && i_wr && i_addr == 5'h00
        ##1 i_ce |=> {o_ctrl.standby, o_ctrl.raw_mode, o_ctrl.half_power,
        o_ctrl.main_input, o_ctrl.agc_on, o_ctrl.supply_5v}
        == {$past(i_wdata[7:6], 2), $past(i_wdata[4:2], 2), $past(i_wdata[0], 2)})
        else $error("power controls wrong");
    AST_FAMILY: assert property (o_ctrl.protocol_code[4:3] == 2'b00
        |-> o_ctrl.family == RMC_FAM_VICINITY)
        else $error("vicinity code wrong family");
    AST_STANDBY: assert property (o_ctrl.standby |=> !o_ctrl.ready)
        else $error("ready during standby");
    AST_FIFO_WR: assert property (i_ce && i_chip_en && i_wr
        && i_addr == 5'h1f |=> o_fifo_wr)
        else $error("no fifo write pulse");
    AST_FIFO_RD: assert property (i_ce && i_chip_en && i_rd
        && i_addr == 5'h1f |=> o_fifo_rd)
        else $error("no fifo read pulse");
    AST_NO_FIFO: assert property (i_ce && !(i_wr && i_addr == 5'h1f)
        |=> !o_fifo_wr)
        else $error("stray fifo write pulse");
endmodule
bind rmc_main_config rmc_main_config_sva u_rmc_main_config_sva (
    .i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_chip_en(i_chip_en),
    .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
    .o_rdata(o_rdata), .o_rd_valid(o_rd_valid), .o_fifo_wr(o_fifo_wr),
    .o_fifo_rd(o_fifo_rd), .o_opt_reload(o_opt_reload), .o_ctrl(o_ctrl)
);

//--- test/rmc_host_model.sv
// Host controller model driving the byte register port.
// Assumes the bench owns clock, reset and both enables.
`timescale 1ns/1ns
module rmc_host_model (
    input  wire logic       i_clk,   // clock
    input  wire logic [7:0] i_rdata, // read data
    input  wire logic       i_valid, // read valid
    output logic            o_wr,    // write strobe
    output logic            o_rd,    // read strobe
    output logic      [4:0] o_addr,  // address
    output logic      [7:0] o_wdata  // write data
);
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 5'h00;
        o_wdata = 8'h00;
    end
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_addr = a;
        o_wdata = (a == 5'h01) ? (d & 8'hdf) : d;
        o_wr = 1'b1;
        @(negedge i_clk);
        o_wr = 1'b0;
        // Idle bus shows junk, not the last value
        o_addr = ~a;
        o_wdata = ~o_wdata;
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] d,
                      output logic v);
        @(negedge i_clk);
        o_addr = a;
        o_rd = 1'b1;
        @(negedge i_clk);
        d = i_rdata;
        v = i_valid;
        o_rd = 1'b0;
        o_addr = ~a;
    endtask
    task automatic raw(input logic vb, input logic [7:0] p);
        wr(5'h01, {1'b0, vb, 6'h02});
        wr(5'h00, p | 8'h40);
    endtask
endmodule

//--- test/reader_main_config_regs_bench.sv
// Bench for the main configuration register pair.
// Host model drives the port; bench drives clock, enables, reset.
`timescale 1ns/1ns
module reader_main_config_regs_bench;
    import rmc_pkg::*;
    logic       i_clk = 1'b0;
    logic       i_reset = 1'b1;
    logic       i_ce = 1'b1;
    logic       i_chip_en = 1'b1;
    logic       i_wr;
    logic       i_rd;
    logic [4:0] i_addr;
    logic [7:0] i_wdata;
    logic [7:0] o_rdata;
    logic       o_rd_valid;
    logic       o_opt_reload;
    rmc_ctrl_t  o_ctrl;
    int         n_errors = 0;
    int         samples_checked = 0;
    always #5 i_clk = ~i_clk;
    rmc_main_config u_rmc_main_config (.i_clk(i_clk), .i_reset(i_reset),
        .i_ce(i_ce), .i_chip_en(i_chip_en), .i_wr(i_wr), .i_rd(i_rd),
        .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
        .o_rd_valid(o_rd_valid), .o_fifo_wr(), .o_fifo_rd(),
        .o_opt_reload(o_opt_reload), .o_ctrl(o_ctrl));
    rmc_host_model u_rmc_host_model (.i_clk(i_clk), .i_rdata(o_rdata),
        .i_valid(o_rd_valid), .o_wr(i_wr), .o_rd(i_rd), .o_addr(i_addr),
        .o_wdata(i_wdata));
    task automatic chk8(input logic [7:0] g, e, input string m);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h", $time, m, g);
        end
    endtask
    task automatic chk1(input logic g, e, input string m);
        chk8({7'h0, g}, {7'h0, e}, m);
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       v;
        u_rmc_host_model.rd(a, d, v);
        chk1(v, 1'b1, "read valid");
        chk8(d, e, "read data");
    endtask
    task automatic t_power();
        logic [7:0] p [2] = '{8'h3d, 8'h02};
        foreach (p[i]) begin
            u_rmc_host_model.wr(5'h00, p[i]);
            @(negedge i_clk);
            chk8({o_ctrl.tx_on, o_ctrl.rx_on, o_ctrl.half_power,
                o_ctrl.main_input, o_ctrl.agc_on, o_ctrl.supply_5v},
                {p[i][5], p[i][5] | p[i][1], p[i][4:2], p[i][0]}, "ctl");
            rdchk(5'h00, p[i]);
        end
    endtask
    task automatic t_proto();
        logic [1:0] f;
        for (int c = 0; c < 32; c++) begin
            f = (c[4:3] == 2'b00) ? 2'b00 : (c[4:2] == 3'b010) ? 2'b01 :
                (c[4:2] == 3'b011) ? 2'b10 : 2'b11;
            u_rmc_host_model.wr(5'h01, {c[0], 2'b00, c[4:0]});
            chk1(o_opt_reload, 1'b1, "reload");
            @(negedge i_clk);
            chk1(o_opt_reload, 1'b0, "reload end");
            chk8({c[0], o_ctrl.protocol_code}, {o_ctrl.no_rx_crc,
                c[4:0]}, "code");
            chk8(o_ctrl.family, f, "family");
        end
        rdchk(5'h01, 8'h9f);
    endtask
    task automatic t_raw();
        u_rmc_host_model.raw(1'b1, 8'h20);
        repeat (2) @(negedge i_clk);
        chk1(o_ctrl.raw_mode, 1'b1, "raw");
        chk1(o_ctrl.raw_variant, 1'b1, "variant");
        u_rmc_host_model.wr(5'h01, 8'h02);
        repeat (2) @(negedge i_clk);
        chk1(o_ctrl.raw_variant, 1'b1, "variant held");
        u_rmc_host_model.wr(5'h00, 8'h20);
        u_rmc_host_model.raw(1'b0, 8'h20);
        repeat (2) @(negedge i_clk);
        chk1(o_ctrl.raw_variant, 1'b0, "variant 0");
    endtask
    task automatic t_chipen();
        i_chip_en = 1'b0;
        repeat (3) @(negedge i_clk);
        i_chip_en = 1'b1;
        i_ce = 1'b0;
        u_rmc_host_model.wr(5'h00, 8'h3c);
        i_ce = 1'b1;
        rdchk(5'h00, 8'h01);
        rdchk(5'h01, 8'h02);
        rdchk(5'h05, 8'h00);
    endtask
    task automatic t_standby();
        u_rmc_host_model.wr(5'h00, 8'h81);
        @(negedge i_clk);
        chk1(o_ctrl.standby, 1'b1, "standby");
        u_rmc_host_model.wr(5'h00, 8'h01);
        repeat (9900) @(negedge i_clk);
        chk1(o_ctrl.ready, 1'b0, "early ready");
        repeat (200) @(negedge i_clk);
        chk1(o_ctrl.ready, 1'b1, "ready");
    endtask
    task automatic results();
        $display("mismatches %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge i_clk);
        i_reset = 1'b0;
        rdchk(5'h00, 8'h01);
        rdchk(5'h01, 8'h02);
        t_power();
        t_proto();
        t_raw();
        t_chipen();
        t_standby();
        results();
    end
    // Run needs about 10300 cycles
    initial begin
        repeat (30000) @(posedge i_clk);
        n_errors++;
        results();
    end
endmodule
